// ==== adc_aux_pkg.sv ====
/*
  Shared constants for the converter auxiliary control block: register offsets,
  field positions, reset values, timing figures and state encodings.
  Assumes a 250 MHz master clock.
*/
package adc_aux_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ADDR_W = 6;
  localparam int REG_W = 16;
  localparam int RESULT_W = 24;
  localparam int SHORT_W = 16;
  localparam int CONV_W = 24;
  localparam int PIN_N = 2;

  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_IFMODE = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_PINCTL = 6'h06;

  localparam logic [REG_W-1:0] MODE_RESET = 16'h8000;
  localparam logic [REG_W-1:0] IFMODE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PINCTL_RESET = 16'h0800;

  localparam int MODE_HIDE_BIT = 14;
  localparam int MODE_DELAY_LSB = 8;
  localparam int MODE_DELAY_W = 3;
  localparam logic [MODE_DELAY_W-1:0] DELAY_SEL_MAX = 3'h7;

  localparam int IF_ALTERNATE_SYNC_ENABLE_BIT = 12;
  localparam int IF_HOLD_BIT = 8;
  localparam int IF_REGCHK_BIT = 5;
  localparam int IF_SHORT_BIT = 0;

  localparam int PC_MUX_BIT = 12;
  localparam int PC_SYNC_EN_BIT = 11;
  localparam int PC_ERRF_LSB = 9;
  localparam int PC_FAULT_PIN_LEVEL_BIT = 8;
  localparam int PC_IN_EN_LSB = 4;
  localparam int PC_OUT_EN_LSB = 2;
  localparam int PC_LEVEL_LSB = 0;

  localparam int ST_READY_BIT = 7;
  localparam int ST_ADC_ERR_BIT = 6;
  localparam int ST_CRC_ERR_BIT = 5;
  localparam int ST_REG_ERR_BIT = 4;
  localparam int ST_FAULT_PIN_LEVEL_BIT = 2;
  localparam int ST_CHAN_LSB = 0;
  localparam int CHAN_W = 2;

  localparam int DELAY_MAX_US = 1000;
  localparam int DOUT_REVERT_NS = 20;
  localparam int REVERT_CYCLES = (DOUT_REVERT_NS * CLK_MHZ / 1000) < 1 ? 1 :
                                 (DOUT_REVERT_NS * CLK_MHZ / 1000);
  localparam int REVERT_W = 4;

  typedef enum logic [1:0] {
    ERRF_OFF = 2'b00,
    ERRF_INPUT = 2'b01,
    ERRF_OUTPUT = 2'b10,
    ERRF_GPOUT = 2'b11
  } err_func_t;

  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_CONVERT = 2'b10,
    SEQ_WAIT_SYNC = 2'b11
  } seq_state_t;
endpackage

// ==== adc_aux_sync_error_ctrl.sv ====
/*
  Auxiliary control around a sigma-delta converter: general-purpose pins,
  shared sync/error pin, pre-sampling delay, result width, data/ready pin
  behaviour, synchronization and error flags.
  Assumes a serial engine on clk supplies register strobes and read framing,
  and a modulator/filter core supplies conversion results.
*/
// Functional notes
// - Input-enabled auxiliary pin level is shown in its level bit.
// - Output-enabled auxiliary pin is driven from its level bit.
// - Error function 11 makes sync/error pin an output from error-data bit.
// - Mux timing bit makes pin changes follow the conversion sequencer.
// - Three-bit mode field picks one of eight delays, zero to 1 ms.
// - Nonzero delay without hide is added to every conversion.
// - Hide with combined sinc and short delay trims averaging as well.
// - Absorption only below 10 kSPS and never at the excepted rates.
// - Short width rounds results to 16 bits; default is 24 bits.
// - Data/ready pin shows ready, data while reading, ready soon after.
// - Hold bit keeps data mode until chip select rises.
// - Sync enable makes the pin an active-low sync input resetting filter.
// - Filter held while sync low, released on next clock after rise.
// - Sync rise starts a conversion; ready fall marks completion.
// - Alternate sync finishes conversion, advances channel, waits for sync high.
// - Range faults set converter error and clamp data until fault ends.
// - Bad write checksum sets CRC error; status read clears it.
// - Register check sets register error on change; clearing check clears it.
// - Register checksum excludes data, status and interface mode registers.
// - Error function 10 drives open-drain low on any error flag.
// - Error function 01 takes an error input into converter error.
`timescale 1ns/100ps
module adc_aux_sync_error_ctrl #(
  parameter int MAX_DELAY_CYCLES = adc_aux_pkg::DELAY_MAX_US * adc_aux_pkg::CLK_MHZ,
  parameter int DLY_W = $clog2(MAX_DELAY_CYCLES + 1)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register access from the serial engine.
  input wire logic regWr,
  input wire logic regWrCrcBad,
  input wire logic regRd,
  input wire logic [adc_aux_pkg::ADDR_W-1:0] regAddr,
  input wire logic [adc_aux_pkg::REG_W-1:0] regWrData,
  output logic [adc_aux_pkg::RESULT_W-1:0] regRdData,
  // Read framing and shared data/ready pin.
  input wire logic readActive,
  input wire logic readBit,
  input wire logic csPin_b,
  output logic doutPin,
  // Filter core.
  input wire logic convDone,
  input wire logic convOverrange,
  input wire logic convUnderrange,
  input wire logic [adc_aux_pkg::RESULT_W-1:0] convResult,
  input wire logic [adc_aux_pkg::CONV_W-1:0] convTimeCycles,
  input wire logic combinedSinc,
  input wire logic rateBelow10k,
  input wire logic rateExcepted,
  output logic filterReset,
  output logic sampleStart,
  output logic channelAdvance,
  output logic [adc_aux_pkg::CHAN_W-1:0] channel,
  output logic [DLY_W-1:0] averageTrim,
  output logic [adc_aux_pkg::RESULT_W-1:0] dataWord,
  // Auxiliary pins, bit 0 is pin a.
  input wire logic [adc_aux_pkg::PIN_N-1:0] auxPinIn,
  output logic [adc_aux_pkg::PIN_N-1:0] auxPinOut,
  output logic [adc_aux_pkg::PIN_N-1:0] auxPinOe_b,
  // Shared sync/error pin.
  input wire logic syncErrPinIn,
  output logic syncErrPinOut,
  output logic syncErrPinOe_b
);
  import adc_aux_pkg::*;

  localparam int REV_MAX = REVERT_CYCLES + 1;

  logic [REG_W-1:0] modeReg, ifMode, pinCtl, checkSnap;
  logic [PIN_N-1:0] auxLvl, applied, inEn, outEn, levelBits;
  logic csLvl, errPinLvl, syncEn, altSync, doutHold, regCheck, shortWidth;
  logic muxTiming, errData, hideDelay, regCheckQ, readActiveQ, dataMode;
  logic readyB, faultLatched, crcErr, regErr, adcErr, anyErr, syncLow, holdReq;
  logic convTaken, timerLoad, timerDone, absorbDelay;
  logic [MODE_DELAY_W-1:0] delaySel;
  logic [DLY_W-1:0] delayCycles;
  logic [REVERT_W-1:0] revCnt;
  logic [RESULT_W-1:0] clamped;
  logic [SHORT_W:0] rounded;
  err_func_t errFunc;
  seq_state_t state, next_state;

  // Pins from outside the clock domain.
  pin_sync2 #(.W(PIN_N + 2)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn({csPin_b, syncErrPinIn, auxPinIn}),
    .pinLvl({csLvl, errPinLvl, auxLvl})
  );

  assign hideDelay = modeReg[MODE_HIDE_BIT];
  assign delaySel = modeReg[MODE_DELAY_LSB +: MODE_DELAY_W];
  assign altSync = ifMode[IF_ALTERNATE_SYNC_ENABLE_BIT];
  assign doutHold = ifMode[IF_HOLD_BIT];
  assign regCheck = ifMode[IF_REGCHK_BIT];
  assign shortWidth = ifMode[IF_SHORT_BIT];
  assign muxTiming = pinCtl[PC_MUX_BIT];
  assign syncEn = pinCtl[PC_SYNC_EN_BIT];
  assign errFunc = err_func_t'(pinCtl[PC_ERRF_LSB +: 2]);
  assign errData = pinCtl[PC_FAULT_PIN_LEVEL_BIT];
  assign inEn = pinCtl[PC_IN_EN_LSB +: PIN_N];
  assign outEn = pinCtl[PC_OUT_EN_LSB +: PIN_N];
  assign levelBits = pinCtl[PC_LEVEL_LSB +: PIN_N];

  // Setting 7 gives the full delay; each lower setting down to 1 halves it, and setting 0 gives none.
  assign delayCycles = (delaySel == '0) ? '0 :
    DLY_W'(MAX_DELAY_CYCLES >> (DELAY_SEL_MAX - delaySel));

  // The delay is always inserted; when hidden and absorbed the filter averages less.
  assign absorbDelay = hideDelay && combinedSinc && rateBelow10k && !rateExcepted &&
    (CONV_W'(delayCycles) < (convTimeCycles >> 1));
  assign averageTrim = absorbDelay ? delayCycles : '0;

  // Register writes; a write with a bad checksum does not land.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      modeReg <= MODE_RESET;
      ifMode <= IFMODE_RESET;
      pinCtl <= PINCTL_RESET;
    end else if (regWr && !regWrCrcBad) begin
      if (regAddr == ADDR_MODE) begin
        modeReg <= regWrData;
      end else if (regAddr == ADDR_IFMODE) begin
        ifMode <= regWrData;
      end else if (regAddr == ADDR_PINCTL) begin
        pinCtl <= regWrData;
      end
    end
  end

  // Register reads.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdData <= '0;
    end else if (regRd) begin
      if (regAddr == ADDR_STATUS) begin
        regRdData <= '0;
        regRdData[ST_READY_BIT] <= readyB;
        regRdData[ST_ADC_ERR_BIT] <= adcErr;
        regRdData[ST_CRC_ERR_BIT] <= crcErr;
        regRdData[ST_REG_ERR_BIT] <= regErr;
        regRdData[ST_FAULT_PIN_LEVEL_BIT] <= (errFunc == ERRF_INPUT) && errPinLvl;
        regRdData[ST_CHAN_LSB +: CHAN_W] <= channel;
      end else if (regAddr == ADDR_MODE) begin
        regRdData <= RESULT_W'(modeReg);
      end else if (regAddr == ADDR_IFMODE) begin
        regRdData <= RESULT_W'(ifMode);
      end else if (regAddr == ADDR_DATA) begin
        regRdData <= dataWord;
      end else if (regAddr == ADDR_PINCTL) begin
        regRdData <= RESULT_W'(pinCtl);
        regRdData[PC_LEVEL_LSB +: PIN_N] <= (inEn & auxLvl) | (~inEn & levelBits);
        if (errFunc == ERRF_INPUT) begin
          regRdData[PC_FAULT_PIN_LEVEL_BIT] <= errPinLvl;
        end
      end else begin
        regRdData <= '0;
      end
    end
  end

  // Auxiliary pins; with mux timing the level only moves at a channel change.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      applied <= '0;
    end else if (!muxTiming || channelAdvance) begin
      applied <= levelBits;
    end
  end

  generate
    for (genvar i = 0; i < PIN_N; i++) begin : g_aux
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          auxPinOut[i] <= 1'b0;
          auxPinOe_b[i] <= 1'b1;
        end else begin
          auxPinOut[i] <= applied[i];
          auxPinOe_b[i] <= !outEn[i];
        end
      end
    end
  endgenerate

  // Shared sync/error pin drive.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      syncErrPinOut <= 1'b0;
      syncErrPinOe_b <= 1'b1;
    end else if (syncEn) begin
      syncErrPinOut <= 1'b0;
      syncErrPinOe_b <= 1'b1;
    end else begin
      case (errFunc)
        ERRF_GPOUT: begin
          syncErrPinOut <= errData;
          syncErrPinOe_b <= 1'b0;
        end
        ERRF_OUTPUT: begin
          syncErrPinOut <= 1'b0;
          syncErrPinOe_b <= !anyErr;
        end
        default: begin
          syncErrPinOut <= 1'b0;
          syncErrPinOe_b <= 1'b1;
        end
      endcase
    end
  end

  // Sync low is caught after two flops; the host holds it one clock or more.
  assign syncLow = syncEn && !errPinLvl;
  assign holdReq = syncLow && !altSync;
  assign filterReset = (state == SEQ_HOLD);
  assign convTaken = (state == SEQ_CONVERT) && convDone && !holdReq;

  always_comb begin
    next_state = state;
    timerLoad = 1'b0;
    case (state)
      SEQ_HOLD: begin
        if (!holdReq) begin
          next_state = SEQ_DELAY;
          timerLoad = 1'b1;
        end
      end
      SEQ_DELAY: begin
        if (timerDone) begin
          next_state = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (convDone) begin
          if (altSync && syncLow) begin
            next_state = SEQ_WAIT_SYNC;
          end else begin
            next_state = SEQ_DELAY;
            timerLoad = 1'b1;
          end
        end
      end
      SEQ_WAIT_SYNC: begin
        if (!syncLow) begin
          next_state = SEQ_DELAY;
          timerLoad = 1'b1;
        end
      end
      default: begin
        next_state = SEQ_HOLD;
      end
    endcase
    if (holdReq) begin
      next_state = SEQ_HOLD;
      timerLoad = 1'b0;
    end
  end

  delay_timer #(.W(DLY_W)) u_delay (
    .clk(clk),
    .rst_b(rst_b),
    .load(timerLoad),
    .count(delayCycles),
    .done(timerDone)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= SEQ_HOLD;
      sampleStart <= 1'b0;
      channelAdvance <= 1'b0;
    end else begin
      state <= next_state;
      sampleStart <= (state == SEQ_DELAY) && timerDone && !holdReq;
      channelAdvance <= convTaken;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel <= '0;
    end else if (channelAdvance) begin
      channel <= channel + 1'b1;
    end
  end

  // Result clamping and rounding; rounding saturates at full scale.
  always_comb begin
    clamped = convResult;
    if (convOverrange) begin
      clamped = '1;
    end else if (convUnderrange) begin
      clamped = '0;
    end
    rounded = {1'b0, clamped[RESULT_W-1 -: SHORT_W]} +
      (SHORT_W + 1)'(clamped[RESULT_W-SHORT_W-1]);
    if (rounded[SHORT_W]) begin
      rounded = {1'b0, {SHORT_W{1'b1}}};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dataWord <= '0;
      faultLatched <= 1'b0;
    end else if (convTaken) begin
      dataWord <= shortWidth ? RESULT_W'(rounded[SHORT_W-1:0]) : clamped;
      faultLatched <= convOverrange || convUnderrange;
    end
  end

  assign adcErr = faultLatched || ((errFunc == ERRF_INPUT) && !errPinLvl);
  assign anyErr = adcErr || crcErr || regErr;

  // Ready goes low on new data and high when a read finishes; new data wins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readyB <= 1'b1;
      readActiveQ <= 1'b0;
    end else begin
      readActiveQ <= readActive;
      if (convTaken) begin
        readyB <= 1'b0;
      end else if (readActiveQ && !readActive) begin
        readyB <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crcErr <= 1'b0;
    end else if (regWrCrcBad) begin
      crcErr <= 1'b1;
    end else if (regRd && (regAddr == ADDR_STATUS)) begin
      crcErr <= 1'b0;
    end
  end

  // Register check snapshot over mode and pin control only.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regCheckQ <= 1'b0;
      checkSnap <= '0;
      regErr <= 1'b0;
    end else begin
      regCheckQ <= regCheck;
      if (!regCheck) begin
        regErr <= 1'b0;
      end else if (!regCheckQ) begin
        checkSnap <= modeReg ^ pinCtl;
      end else if ((modeReg ^ pinCtl) != checkSnap) begin
        regErr <= 1'b1;
      end
    end
  end

  // Data/ready pin; the last data bit stands until the pin reverts.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dataMode <= 1'b0;
      revCnt <= '0;
      doutPin <= 1'b1;
    end else begin
      if (readActive) begin
        dataMode <= 1'b1;
        revCnt <= REVERT_W'(REVERT_CYCLES);
      end else if (dataMode) begin
        if (doutHold) begin
          dataMode <= !csLvl;
        end else if (revCnt <= 1) begin
          dataMode <= 1'b0;
        end else begin
          revCnt <= revCnt - 1'b1;
        end
      end
      doutPin <= readActive ? readBit : (dataMode ? doutPin : readyB);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sync_release;
    filterReset ##1 !holdReq;
  endsequence
  sequence s_read_end;
    readActive ##1 !readActive;
  endsequence

  property p_gp_input;
    regRd && (regAddr == ADDR_PINCTL) && inEn[0] |=> regRdData[0] == $past(auxLvl[0]);
  endproperty
  a_gp_input: assert property (p_gp_input) else $error("input pin level not shown");
  property p_gp_output;
    !muxTiming && outEn[0] ##1 outEn[0] |=> auxPinOut[0] == $past(levelBits[0], 2) &&
      !auxPinOe_b[0];
  endproperty
  a_gp_output: assert property (p_gp_output) else $error("aux pin not driven");
  property p_err_gpout;
    !syncEn && (errFunc == ERRF_GPOUT) |=> !syncErrPinOe_b && syncErrPinOut == $past(errData);
  endproperty
  a_err_gpout: assert property (p_err_gpout) else $error("error pin output wrong");
  property p_mux_timing;
    muxTiming && !channelAdvance |=> $stable(applied);
  endproperty
  a_mux_timing: assert property (p_mux_timing) else $error("pin moved off sequencer");
  property p_delay_full;
    delaySel == DELAY_SEL_MAX |-> delayCycles == DLY_W'(MAX_DELAY_CYCLES);
  endproperty
  a_delay_full: assert property (p_delay_full) else $error("full delay wrong");
  property p_delay_zero_start;
    timerLoad && delayCycles == '0 |-> ##3 (sampleStart || $past(holdReq) || $past(holdReq, 2));
  endproperty
  a_delay_zero_start: assert property (p_delay_zero_start) else $error("zero delay late");
  property p_absorb;
    averageTrim != '0 |-> hideDelay && combinedSinc && rateBelow10k && !rateExcepted;
  endproperty
  a_absorb: assert property (p_absorb) else $error("delay absorbed wrongly");
  property p_short;
    convTaken && shortWidth |=> dataWord[RESULT_W-1:SHORT_W] == '0;
  endproperty
  a_short: assert property (p_short) else $error("short result too wide");
  property p_revert;
    s_read_end ##0 !doutHold |-> ##[1:REV_MAX] !dataMode || readActive || doutHold;
  endproperty
  a_revert: assert property (p_revert) else $error("pin did not revert");
  property p_hold;
    dataMode && doutHold && !csLvl && !readActive |=> dataMode;
  endproperty
  a_hold: assert property (p_hold) else $error("data mode dropped early");
  property p_sync_hold;
    holdReq |=> filterReset;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("filter not held");
  property p_release;
    s_sync_release |=> !filterReset;
  endproperty
  a_release: assert property (p_release) else $error("filter not released");
  property p_alt;
    convTaken && altSync && syncLow |=> state == SEQ_WAIT_SYNC && channelAdvance;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate sync wrong");
  property p_over;
    convTaken && convOverrange && !shortWidth |=> dataWord == '1 && adcErr;
  endproperty
  a_over: assert property (p_over) else $error("overrange not flagged");
  property p_crc;
    regWrCrcBad |=> crcErr;
  endproperty
  a_crc: assert property (p_crc) else $error("crc error lost");
  property p_regchk;
    !regCheck |=> !regErr;
  endproperty
  a_regchk: assert property (p_regchk) else $error("register error not cleared");
  property p_err_out;
    !syncEn && (errFunc == ERRF_OUTPUT) && anyErr |=> !syncErrPinOe_b && !syncErrPinOut;
  endproperty
  a_err_out: assert property (p_err_out) else $error("error output not low");
  property p_err_in;
    errFunc == ERRF_INPUT && !errPinLvl |-> adcErr;
  endproperty
  a_err_in: assert property (p_err_in) else $error("error input not merged");
endmodule // adc_aux_sync_error_ctrl

// ==== delay_timer.sv ====
/*
  Down-counter that emits a one-cycle done pulse a set number of cycles
  after a load. Assumes load and count come from logic on the same clock.
*/
`timescale 1ns/100ps
module delay_timer #(
  parameter int W = 18
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Load request and its count; done follows count plus one cycles later.
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] remain;
  logic running;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      remain <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        running <= 1'b1;
      end else if (running) begin
        if (remain == '0) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - 1'b1;
        end
      end
    end
  end
endmodule // delay_timer

// ==== host_model.sv ====
/*
  Host model: register strobes from the serial engine, chip select and sync pin.
  Assumes the bench calls its tasks and that everything runs on clk.
*/
`timescale 1ns/100ps
module host_model (
  // Clock.
  input wire logic clk,
  // Register strobes and read data.
  output logic regWr,
  output logic regWrCrcBad,
  output logic regRd,
  output logic [5:0] regAddr,
  output logic [15:0] regWrData,
  input wire logic [23:0] regRdData,
  // Pins.
  output logic csPin_b,
  output logic syncPin
);
  initial begin
    {regWr, regWrCrcBad, regRd} = 3'h0;
    regAddr = 6'h3f;
    regWrData = 16'h0;
    csPin_b = 1'b1;
    syncPin = 1'b1;
  end
  // Each access is framed by chip select; released lines show the inverse.
  task acc(input logic w, b, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    {regWr, regWrCrcBad, regRd} = {w & ~b, b, ~w};
    regAddr = a;
    regWrData = d;
    csPin_b = 1'b0;
    @(posedge clk) #1;
    {regWr, regWrCrcBad, regRd} = 3'h0;
    regAddr = ~a;
    regWrData = ~d;
    csPin_b = 1'b1;
  endtask
  // Sync moves just after a rising edge and stays at least one cycle.
  task sync_set(input logic v);
    @(posedge clk) #1;
    syncPin = v;
    @(posedge clk) #1;
  endtask
  // Chip select alone, for data reads that the host frames itself.
  task cs_set(input logic v);
    @(posedge clk) #1;
    csPin_b = v;
  endtask
endmodule // host_model

// ==== pin_sync2.sv ====
/*
  Two-stage synchronizer for a group of pin inputs.
  Assumes the inputs are asynchronous to clk and the reset is synchronous.
*/
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Pins and their synchronized levels.
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinLvl
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= '1;
      pinLvl <= '1;
    end else begin
      stage1 <= pinIn;
      pinLvl <= stage1;
    end
  end
endmodule // pin_sync2

// ==== tb.sv ====
/*
  Self-checking bench for the converter auxiliary control block.
  Assumes host_model supplies register access and the sync pin.
*/
`timescale 1ns/100ps
module tb;
  import adc_aux_pkg::*;
  logic clk, rst_b, readActive, readBit, convDone, convOverrange, convUnderrange;
  logic combinedSinc, rateBelow10k, rateExcepted, filterReset, sampleStart, doutPin;
  logic regWr, regWrCrcBad, regRd, csPin_b, syncPin, syncErrPinOut, syncErrPinOe_b;
  logic [5:0] regAddr;
  logic [15:0] regWrData;
  logic [23:0] regRdData, convResult, convTimeCycles, dataWord, q, r;
  logic [6:0] averageTrim;
  logic [1:0] auxPinIn, auxPinOut, auxPinOe_b, v;
  int failures, checked, n, cyc, starts, used;
  host_model host_model_i (.clk(clk), .regWr(regWr), .regWrCrcBad(regWrCrcBad),
    .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .csPin_b(csPin_b), .syncPin(syncPin));
  adc_aux_sync_error_ctrl #(.MAX_DELAY_CYCLES(64)) adc_aux_sync_error_ctrl_i (.clk(clk),
    .rst_b(rst_b), .regWr(regWr), .regWrCrcBad(regWrCrcBad), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .readActive(readActive), .readBit(readBit), .csPin_b(csPin_b), .doutPin(doutPin),
    .convDone(convDone), .convOverrange(convOverrange), .convUnderrange(convUnderrange),
    .convResult(convResult), .convTimeCycles(convTimeCycles), .combinedSinc(combinedSinc),
    .rateBelow10k(rateBelow10k), .rateExcepted(rateExcepted), .filterReset(filterReset),
    .sampleStart(sampleStart), .channelAdvance(), .channel(), .averageTrim(averageTrim),
    .dataWord(dataWord), .auxPinIn(auxPinIn), .auxPinOut(auxPinOut),
    .auxPinOe_b(auxPinOe_b), .syncErrPinIn(syncPin), .syncErrPinOut(syncErrPinOut),
    .syncErrPinOe_b(syncErrPinOe_b));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (sampleStart === 1'b1) starts++;
    if (cyc == 20000) begin
      failures++;
      stop_test;
    end
  end
  task stop_test;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [23:0] g, e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [5:0] a, input logic [15:0] d, input logic b);
    host_model_i.acc(1'b1, b, a, d);
  endtask
  task rd(input logic [5:0] a);
    host_model_i.acc(1'b0, 1'b0, a, 16'h0);
    q = regRdData;
  endtask
  // Waits for a sampling start not yet used, then hands one result to the block.
  task conv(input logic [23:0] res, input logic ovr);
    n = 0;
    while (starts == used && n < 500) begin
      cy(1);
      n++;
    end
    used = starts;
    chk(n < 500, 1);
    {convResult, convOverrange, convDone} = {res, ovr, 1'b1};
    cy(1);
    {convOverrange, convDone} = 2'b00;
  endtask
  function logic [15:0] rnd(input logic [23:0] x);
    rnd = (x[23:8] == 16'hffff) ? 16'hffff : x[23:8] + 16'(x[7]);
  endfunction
  initial begin
    {rst_b, readActive, readBit, convDone, convOverrange, convUnderrange} = 6'h0;
    {combinedSinc, rateBelow10k, rateExcepted} = 3'b110;
    {convResult, convTimeCycles, auxPinIn} = {24'h0, 24'd1000, 2'b00};
    q = $urandom(32'h82d54db5);
    cy(5);
    rst_b = 1'b1;
    rd(6'h01); chk(q, 24'h8000);
    rd(6'h02); chk(q, 24'h0);
    rd(6'h06); chk(q, 24'h0800);
    rd(6'h3f); chk(q, 24'h0);
    host_model_i.sync_set(1'b0);
    cy(3); chk(filterReset, 1);
    used = starts;
    wr(6'h01, 16'h0700, 1'b0);
    rd(6'h06); chk(q, 24'h0800);
    host_model_i.sync_set(1'b1);
    conv(24'h0, 1'b0); chk(n >= 64 && n <= 75, 1);
    wr(6'h01, 16'h4700, 1'b0);
    chk(averageTrim, 64);
    rateExcepted = 1'b1;
    cy(1); chk(averageTrim, 0);
    {rateExcepted, rateBelow10k} = 2'b00;
    cy(1); chk(averageTrim, 0);
    rateBelow10k = 1'b1;
    wr(6'h01, 16'h0000, 1'b0);
    wr(6'h06, 16'h000c, 1'b0);
    for (int i = 0; i < 6; i++) begin
      r = (i < 2) ? 24'hffffff : 24'($urandom);
      wr(6'h02, {15'h0, i[0]}, 1'b0);
      conv(r, 1'b0);
      chk(i[0] ? dataWord[15:0] : dataWord, i[0] ? rnd(r) : r);
      chk(doutPin, 0);
    end
    chk(n < 12, 1);
    {readActive, readBit} = 2'b11;
    cy(1); chk(doutPin, 1);
    readBit = 1'b0;
    cy(1); readActive = 1'b0;
    cy(2); chk(doutPin, 0);
    cy(4); chk(doutPin, 1);
    wr(6'h02, 16'h0100, 1'b0);
    host_model_i.cs_set(1'b0);
    cy(2); readActive = 1'b1;
    cy(1); readActive = 1'b0;
    cy(9); chk(doutPin, 0);
    host_model_i.cs_set(1'b1);
    cy(5); chk(doutPin, 1);
    wr(6'h02, 16'h0000, 1'b0);
    conv(24'h123456, 1'b1);
    rd(6'h00); chk(q[6], 1);
    conv(24'h000100, 1'b0);
    rd(6'h00); chk(q[6], 0);
    wr(6'h06, 16'h100f, 1'b0);
    cy(4); chk(auxPinOut, 0);
    conv(24'h0, 1'b0);
    cy(3); chk(auxPinOut, 3);
    for (int i = 0; i < 4; i++) begin
      v = 2'($urandom);
      wr(6'h06, {14'h0003, v}, 1'b0);
      cy(3); chk(auxPinOut, v);
      chk(auxPinOe_b, 0);
      wr(6'h06, 16'h0030, 1'b0);
      auxPinIn = ~v;
      cy(4); rd(6'h06); chk(q[1:0], 2'(~v));
      chk(auxPinOe_b, 3);
    end
    wr(6'h06, 16'h0700, 1'b0);
    cy(3); chk({syncErrPinOe_b, syncErrPinOut}, 1);
    wr(6'h06, 16'h0400, 1'b0);
    wr(6'h06, 16'h0700, 1'b1);
    cy(3); chk(syncErrPinOe_b, 0);
    rd(6'h06); chk(q, 24'h0400);
    rd(6'h00); chk(q[5], 1);
    rd(6'h00); chk(q[5], 0);
    cy(3); chk(syncErrPinOe_b, 1);
    wr(6'h06, 16'h0200, 1'b0);
    host_model_i.sync_set(1'b0);
    cy(3); rd(6'h00); chk({q[6], q[2]}, 2);
    host_model_i.sync_set(1'b1);
    wr(6'h02, 16'h0020, 1'b0);
    wr(6'h01, 16'h0100, 1'b0);
    cy(2); rd(6'h00); chk(q[4], 1);
    wr(6'h02, 16'h0000, 1'b0);
    cy(2); rd(6'h00); chk(q[4], 0);
    wr(6'h06, 16'h0800, 1'b0);
    wr(6'h02, 16'h1000, 1'b0);
    host_model_i.sync_set(1'b0);
    cy(2); conv(24'h000200, 1'b0); chk(filterReset, 0);
    chk(dataWord, 24'h000200);
    rd(6'h00); chk(q[1:0], 2'h3);
    cy(8); chk(starts == used, 1);
    host_model_i.sync_set(1'b1);
    conv(24'h000300, 1'b0); chk(dataWord, 24'h000300);
    stop_test;
  end
endmodule // tb
